/* File: dv/acc_ctrl_properties.sv */
// Checker: port-level properties of the calibration control register group
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_props (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Device side
    input wire logic serial_output_enable,
    input wire logic div_rst_n,
    input wire logic [2:0] subconv_enable,
    input wire logic [1:0] standin_target,
    input wire logic irq
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Accepted accesses; a strobe with the enable low is not taken
    sequence s_write(a);
        reg_wr && clk_en && reg_addr == a;
    endsequence
    sequence s_read(a);
        reg_rd && clk_en && reg_addr == a;
    endsequence
    a_run_divider: assert property (s_write(8'h61) |=> div_rst_n == $past(reg_wdata[0]))
        else $error("divider reset does not follow run bit");
    a_hold_serial: assert property (!div_rst_n |-> !serial_output_enable)
        else $error("serial output enabled while calibration held");
    a_serial_follow: assert property (s_write(8'h72) ##0 div_rst_n |=> serial_output_enable == $past(reg_wdata[0]))
        else $error("serial output enable does not follow its write");
    a_run_readback: assert property (s_read(8'h61) |=> reg_rdata == {7'h00, div_rst_n})
        else $error("run register readback wrong");
    a_idle_reserved: assert property (s_read(8'h64) |=> reg_rdata[7:2] == 6'h00)
        else $error("idle select reserved bits nonzero");
    a_flags_hold: assert property (s_read(8'h6a) ##0 (!div_rst_n && $past(div_rst_n, 2) == 1'b0) |=> reg_rdata == 8'h00)
        else $error("status flags nonzero while held");
    a_standin_legal: assert property (standin_target != 2'h1)
        else $error("second converter stands in for itself");
    a_standin_first: assert property (standin_target == 2'h0 |-> subconv_enable == 3'b110)
        else $error("first converter not idled");
    a_standin_third: assert property (standin_target == 2'h2 |-> subconv_enable == 3'b011)
        else $error("third converter not idled");
    a_mask_quiet: assert property (s_write(8'h71) ##0 reg_wdata[1:0] == 2'h0 |=> !irq)
        else $error("interrupt high with empty mask");
    a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
endmodule : acc_ctrl_props
bind acc_ctrl acc_ctrl_props i_props (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_output_enable(serial_output_enable), .div_rst_n(div_rst_n),
    .subconv_enable(subconv_enable), .standin_target(standin_target), .irq(irq));
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the calibration control register group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Design signals
    logic clock, rst_n, clk_en, reg_wr, reg_rd, serial_output_enable, div_rst_n, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, f;
    logic [2:0] subconv_enable;
    logic [1:0] standin_target;
    // Register model and counters
    logic [7:0] mdl [256];
    logic [7:0] raddr [6] = '{8'h61, 8'h62, 8'h64, 8'h68, 8'h71, 8'h72};
    int mismatches, tests_run, t_a, t_b;
    acc_ctrl i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_output_enable(serial_output_enable), .div_rst_n(div_rst_n),
        .subconv_enable(subconv_enable), .standin_target(standin_target), .irq(irq));
    // Writable bits; all else but flags and interrupt status reads back zero
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'h61, 8'h72: return 8'h01;
            8'h62: return 8'h0f;
            8'h64, 8'h71: return 8'h03;
            8'h68: return 8'h77;
            default: return 8'h00;
        endcase
    endfunction : wmask
    // Stand-in target and enables per idle code; code 3 idles nothing
    function automatic logic [4:0] idle_exp(input logic [1:0] c);
        case (c)
            2'h0: return {2'h0, 3'b110};
            2'h1: return {2'h3, 3'b101};
            2'h2: return {2'h2, 3'b011};
            default: return {2'h3, 3'b111};
        endcase
    endfunction : idle_exp
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bus cycles; model follows only writes the enable let through
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (clk_en) mdl[a] = d & wmask(a);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rdchk(input logic [7:0] a);
        rd(a, f);
        chk("readback", mdl[a], f);
    endtask : rdchk
    // Pin levels after the last write has landed
    task automatic pins();
        #1;
        chk("div_rst_n", {7'h0, mdl[8'h61][0]}, {7'h0, div_rst_n});
        chk("ser_en", {7'h0, mdl[8'h72][0] & mdl[8'h61][0]}, {7'h0, serial_output_enable});
        if (!mdl[8'h62][1]) chk("idle", {3'h0, idle_exp(mdl[8'h64][1:0])}, {3'h0, standin_target, subconv_enable});
    endtask : pins
    task automatic irqchk(input logic e);
        #1 chk("irq", {7'h0, e}, {7'h0, irq});
    endtask : irqchk
    // Start calibration from hold and count polls until done; a hang counts as a mismatch
    task automatic restart(output int cyc);
        wr(8'h61, 8'h01);
        cyc = 0;
        do begin
            rd(8'h6a, f);
            cyc++;
        end while (f[0] !== 1'b1 && cyc < 4000);
        chk("foreground_complete_flag", 8'h01, {7'h0, f[0]});
    endtask : restart
    task automatic summarize();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // Clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        mismatches++;
        summarize();
    end
    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        clk_en = 1'b1;
        mismatches = 0;
        tests_run = 0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[8'h61] = 8'h01;
        mdl[8'h62] = 8'h01;
        mdl[8'h64] = 8'h02;
        mdl[8'h68] = 8'h61;
        void'($urandom(88286));
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (raddr[i]) rdchk(raddr[i]);
        pins();
        // Random settings while held, serial link off
        wr(8'h61, 8'h00);
        repeat (24) begin
            t_a = 1 + $urandom_range(3);
            // Reserved positions written as zero
            wr(raddr[t_a], 8'($urandom) & wmask(raddr[t_a]));
            rdchk(raddr[t_a]);
            pins();
        end
        wr(8'h62, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h64, 8'(c));
            pins();
        end
        // Hold clears flags; status and unmapped places ignore writes
        rd(8'h6a, f);
        chk("flags_hold", 8'h00, f);
        wr(8'h6a, 8'h1f);
        wr(8'h55, 8'hff);
        rd(8'h6a, f);
        chk("flags_ro", 8'h00, f);
        rdchk(8'h55);
        // Skipped foreground, then each interrupt source
        wr(8'h64, 8'h02);
        wr(8'h71, 8'h00);
        wr(8'h70, 8'h03);
        restart(t_a);
        chk("flags_skip", {3'h0, acc_pkg::STAT_DONE, 2'b11}, f);
        chk("skip_quick", 8'h01, {7'h0, t_a < 4});
        rd(8'h70, f);
        chk("irq_stat", 8'h03, f);
        irqchk(1'b0);
        for (int b = 0; b < 2; b++) begin
            wr(8'h71, 8'(1 << b));
            irqchk(1'b1);
            wr(8'h70, 8'(1 << b));
            irqchk(1'b0);
        end
        rd(8'h70, f);
        chk("irq_clear", 8'h00, f);
        // Offset select alone does nothing without foreground
        wr(8'h61, 8'h00);
        wr(8'h62, 8'h04);
        restart(t_a);
        chk("ofs_alone", 8'h01, {7'h0, t_a < 4});
        // Averaging depth lengthens each pass
        wr(8'h61, 8'h00);
        wr(8'h62, 8'h01);
        wr(8'h68, 8'h00);
        restart(t_a);
        wr(8'h61, 8'h00);
        wr(8'h68, 8'h02);
        restart(t_b);
        chk("lin_longer", 8'h01, {7'h0, t_b > t_a});
        chk("flags_fg", {3'h0, acc_pkg::STAT_DONE, 2'b11}, f);
        wr(8'h61, 8'h00);
        wr(8'h62, 8'h05);
        wr(8'h68, 8'h10);
        restart(t_a);
        wr(8'h61, 8'h00);
        wr(8'h68, 8'h30);
        restart(t_b);
        chk("os_longer", 8'h01, {7'h0, t_b > t_a});
        // Background keeps running, so not stopped
        wr(8'h61, 8'h00);
        wr(8'h62, 8'h0b);
        restart(t_a);
        chk("flags_bg", {3'h0, acc_pkg::STAT_BG, 2'b01}, f);
        // Serial link on after run, off before hold
        wr(8'h72, 8'h01);
        pins();
        wr(8'h72, 8'h00);
        wr(8'h61, 8'h00);
        pins();
        // Frozen enable drops a write
        @(posedge clock);
        clk_en <= 1'b0;
        wr(8'h68, 8'h44);
        clk_en <= 1'b1;
        rdchk(8'h68);
        summarize();
    end
endmodule : tb_top
`default_nettype wire

/* File: include/acc_pkg.sv */
// Package: register map, field layout, reset values and timing for calibration control
package acc_pkg;
    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_RUN = 8'h61;
    localparam logic [7:0] ADDR_MODE = 8'h62;
    localparam logic [7:0] ADDR_IDLE = 8'h64;
    localparam logic [7:0] ADDR_AVG = 8'h68;
    localparam logic [7:0] ADDR_FLAGS = 8'h6a;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h70;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h71;
    localparam logic [7:0] ADDR_SER_EN = 8'h72;
    // Reset values
    localparam logic [7:0] RST_RUN = 8'h01;
    localparam logic [7:0] RST_MODE = 8'h01;
    localparam logic [7:0] RST_IDLE = 8'h02;
    localparam logic [7:0] RST_AVG = 8'h61;
    // Field positions
    localparam int FG_BIT = 0;
    localparam int BG_BIT = 1;
    localparam int FOS_BIT = 2;
    localparam int BOS_BIT = 3;
    localparam int OFFSET_AVERAGING_DEPTH_LSB = 4;
    localparam int LIN_AVG_LSB = 0;
    localparam int STAT_LSB = 2;
    localparam int STOP_BIT = 1;
    localparam int DONE_BIT = 0;
    // Idle sub-converter codes
    localparam logic [1:0] IDLE_FIRST = 2'h0;
    localparam logic [1:0] IDLE_SECOND = 2'h1;
    localparam logic [1:0] IDLE_THIRD = 2'h2;
    // Cycle counts of the stand-in calibration sequencer
    localparam int CLK_MHZ = 25;
    localparam int STEP_NS = 80;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int BG_PASS_BASE = 16;
    localparam int DIV_RATIO = 4;
    // Sequencer states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ACC_HOLD = 3'b000,
        ACC_FG_LIN = 3'b001,
        ACC_FG_OFS = 3'b011,
        ACC_BG_RUN = 3'b010,
        ACC_DONE = 3'b110
    } acc_state_t;
    // Status codes shown in the status register
    localparam logic [2:0] STAT_HOLD = 3'h0;
    localparam logic [2:0] STAT_FG = 3'h1;
    localparam logic [2:0] STAT_BG = 3'h2;
    localparam logic [2:0] STAT_DONE = 3'h3;
    localparam logic [2:0] STAT_RESERVED = 3'h7;
endpackage : acc_pkg

/* File: include/acc_seq_if.sv */
// Interface: settings and status between register file and calibration sequencer
`timescale 1ns/1ps
`default_nettype none
interface acc_seq_if;
    logic run;
    logic fg_sel;
    logic bg_sel;
    logic fos_sel;
    logic bos_sel;
    logic [2:0] offset_averaging_depth;
    logic [2:0] lin_avg;
    logic foreground_complete_flag;
    logic stopped;
    logic [2:0] stat;
    logic div_clear;
    modport regs (output run, fg_sel, bg_sel, fos_sel, bos_sel, offset_averaging_depth, lin_avg,
        input foreground_complete_flag, stopped, stat, div_clear);
    modport seq (input run, fg_sel, bg_sel, fos_sel, bos_sel, offset_averaging_depth, lin_avg,
        output foreground_complete_flag, stopped, stat, div_clear);
endinterface : acc_seq_if
`default_nettype wire

/* File: logic/acc_ctrl.sv */
// Calibration control register group with divider reset and interrupt
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Device side
    output logic serial_output_enable,
    output logic div_rst_n,
    output logic [2:0] subconv_enable,
    output logic [1:0] standin_target,
    output logic irq
);
    logic rst_meta_n, rst_sync_n;
    logic run, next_run;
    logic [3:0] mode, next_mode;
    logic [1:0] idle_sel, next_idle_sel;
    logic [2:0] offset_averaging_depth, next_offset_averaging_depth;
    logic [2:0] lin_avg, next_lin_avg;
    logic ser_en, next_ser_en;
    logic [1:0] irq_stat, next_irq_stat;
    logic [1:0] irq_mask, next_irq_mask;
    logic [7:0] next_rdata;
    logic done_q, stop_q;
    logic [1:0] events;
    acc_seq_if sif ();

    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Write decode and sticky event flags
    always_comb begin
        next_run = run;
        next_mode = mode;
        next_idle_sel = idle_sel;
        next_offset_averaging_depth = offset_averaging_depth;
        next_lin_avg = lin_avg;
        next_ser_en = ser_en;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (reg_wr) begin
            if (reg_addr == acc_pkg::ADDR_RUN) begin
                next_run = reg_wdata[0];
            end else if (reg_addr == acc_pkg::ADDR_MODE) begin
                next_mode = reg_wdata[3:0];
            end else if (reg_addr == acc_pkg::ADDR_IDLE) begin
                next_idle_sel = reg_wdata[1:0];
            end else if (reg_addr == acc_pkg::ADDR_AVG) begin
                next_offset_averaging_depth = reg_wdata[acc_pkg::OFFSET_AVERAGING_DEPTH_LSB +: 3];
                next_lin_avg = reg_wdata[acc_pkg::LIN_AVG_LSB +: 3];
            end else if (reg_addr == acc_pkg::ADDR_IRQ_STAT) begin
                next_irq_stat = irq_stat & ~reg_wdata[1:0];
            end else if (reg_addr == acc_pkg::ADDR_IRQ_MASK) begin
                next_irq_mask = reg_wdata[1:0];
            end else if (reg_addr == acc_pkg::ADDR_SER_EN) begin
                next_ser_en = reg_wdata[0];
            end
        end
        // Set wins over a same-cycle clear
        next_irq_stat = next_irq_stat | events;
    end

    // Rising edges of done and stopped are the events
    assign events = {sif.stopped & ~stop_q, sif.foreground_complete_flag & ~done_q};

    // Read mux; status is read-only, writes there are dropped
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == acc_pkg::ADDR_RUN) begin
                next_rdata = {7'h00, run};
            end else if (reg_addr == acc_pkg::ADDR_MODE) begin
                next_rdata = {4'h0, mode};
            end else if (reg_addr == acc_pkg::ADDR_IDLE) begin
                next_rdata = {6'h00, idle_sel};
            end else if (reg_addr == acc_pkg::ADDR_AVG) begin
                next_rdata = {1'b0, offset_averaging_depth, 1'b0, lin_avg};
            end else if (reg_addr == acc_pkg::ADDR_FLAGS) begin
                next_rdata = {3'h0, sif.stat, sif.stopped, sif.foreground_complete_flag};
            end else if (reg_addr == acc_pkg::ADDR_IRQ_STAT) begin
                next_rdata = {6'h00, irq_stat};
            end else if (reg_addr == acc_pkg::ADDR_IRQ_MASK) begin
                next_rdata = {6'h00, irq_mask};
            end else if (reg_addr == acc_pkg::ADDR_SER_EN) begin
                next_rdata = {7'h00, ser_en};
            end
        end
    end

    // Register file flip-flops
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run <= acc_pkg::RST_RUN[0];
            mode <= acc_pkg::RST_MODE[3:0];
            idle_sel <= acc_pkg::RST_IDLE[1:0];
            offset_averaging_depth <= acc_pkg::RST_AVG[acc_pkg::OFFSET_AVERAGING_DEPTH_LSB +: 3];
            lin_avg <= acc_pkg::RST_AVG[acc_pkg::LIN_AVG_LSB +: 3];
            ser_en <= 1'b0;
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            reg_rdata <= 8'h00;
            done_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (clk_en) begin
            run <= next_run;
            mode <= next_mode;
            idle_sel <= next_idle_sel;
            offset_averaging_depth <= next_offset_averaging_depth;
            lin_avg <= next_lin_avg;
            ser_en <= next_ser_en;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            reg_rdata <= next_rdata;
            done_q <= sif.foreground_complete_flag;
            stop_q <= sif.stopped;
        end
    end

    // Settings to the sequencer
    assign sif.run = run;
    assign sif.fg_sel = mode[acc_pkg::FG_BIT];
    assign sif.bg_sel = mode[acc_pkg::BG_BIT];
    assign sif.fos_sel = mode[acc_pkg::FOS_BIT] & mode[acc_pkg::FG_BIT];
    assign sif.bos_sel = mode[acc_pkg::BOS_BIT] & mode[acc_pkg::BG_BIT];
    assign sif.offset_averaging_depth = offset_averaging_depth;
    assign sif.lin_avg = lin_avg;

    acc_seq u_seq (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .clk_en(clk_en),
        .sq(sif.seq)
    );

    // Idle sub-converter choice; background keeps all three active
    always_comb begin
        subconv_enable = 3'b111;
        standin_target = 2'h3;
        if (!sif.bg_sel) begin
            case (idle_sel)
                acc_pkg::IDLE_FIRST: begin
                    subconv_enable = 3'b110;
                    standin_target = acc_pkg::IDLE_FIRST;
                end
                acc_pkg::IDLE_SECOND: subconv_enable = 3'b101;
                acc_pkg::IDLE_THIRD: begin
                    subconv_enable = 3'b011;
                    standin_target = acc_pkg::IDLE_THIRD;
                end
                default: subconv_enable = 3'b111; // Reserved code idles none
            endcase
        end
    end

    // Dividers held in reset while calibration is held
    assign div_rst_n = !sif.div_clear;
    // Gate serial enable by run so a wrong host order cannot stream bad data
    assign serial_output_enable = ser_en & run;
    assign irq = |(irq_stat & irq_mask);
endmodule : acc_ctrl
`default_nettype wire

/* File: logic/acc_seq.sv */
// Calibration sequencer: foreground and background passes with averaging depth
`timescale 1ns/1ps
`default_nettype none
module acc_seq (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_sync_n,
    input wire logic clk_en,
    // Settings and status
    acc_seq_if.seq sq
);
    acc_pkg::acc_state_t state, next_state;
    logic [11:0] cnt, next_cnt;
    logic foreground_complete_flag, next_foreground_complete_flag;
    logic stopped, next_stopped;

    // Pass length grows with the averaging code, so larger codes average more
    function automatic logic [11:0] pass_len(input logic [2:0] code);
        pass_len = 12'(acc_pkg::BG_PASS_BASE << code);
    endfunction : pass_len

    // Next state of the sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_foreground_complete_flag = foreground_complete_flag;
        next_stopped = stopped;
        if (!sq.run) begin
            // Run low returns to hold and clears count and flags
            next_state = acc_pkg::ACC_HOLD;
            next_cnt = 12'h000;
            next_foreground_complete_flag = 1'b0;
            next_stopped = 1'b0;
        end else begin
            case (state)
                acc_pkg::ACC_HOLD: begin
                    next_cnt = 12'h000;
                    if (sq.fg_sel) begin
                        next_state = acc_pkg::ACC_FG_LIN;
                    end else begin
                        next_foreground_complete_flag = 1'b1;
                        next_state = sq.bg_sel ? acc_pkg::ACC_BG_RUN : acc_pkg::ACC_DONE;
                        next_stopped = !sq.bg_sel;
                    end
                end
                acc_pkg::ACC_FG_LIN: begin
                    next_cnt = cnt + 12'h001;
                    if (cnt >= pass_len(sq.lin_avg)) begin
                        next_cnt = 12'h000;
                        // Offset pass only with foreground selected
                        next_state = sq.fos_sel ? acc_pkg::ACC_FG_OFS : acc_pkg::ACC_BG_RUN;
                        if (!sq.fos_sel) begin
                            next_foreground_complete_flag = 1'b1;
                            next_state = sq.bg_sel ? acc_pkg::ACC_BG_RUN : acc_pkg::ACC_DONE;
                            next_stopped = !sq.bg_sel;
                        end
                    end
                end
                acc_pkg::ACC_FG_OFS: begin
                    next_cnt = cnt + 12'h001;
                    if (cnt >= pass_len(sq.offset_averaging_depth)) begin
                        next_cnt = 12'h000;
                        next_foreground_complete_flag = 1'b1;
                        next_state = sq.bg_sel ? acc_pkg::ACC_BG_RUN : acc_pkg::ACC_DONE;
                        next_stopped = !sq.bg_sel;
                    end
                end
                acc_pkg::ACC_BG_RUN: begin
                    // Continuous passes; pass length follows the offset averaging depth when enabled
                    next_cnt = cnt + 12'h001;
                    next_stopped = 1'b0;
                    if (!sq.bg_sel) begin
                        next_state = acc_pkg::ACC_DONE;
                        next_stopped = 1'b1;
                    end else if (cnt >= pass_len((sq.bos_sel) ? sq.offset_averaging_depth : sq.lin_avg)) begin
                        next_cnt = 12'h000;
                    end
                end
                acc_pkg::ACC_DONE: begin
                    if (sq.bg_sel) begin
                        next_state = acc_pkg::ACC_BG_RUN;
                        next_stopped = 1'b0;
                    end
                end
                default: next_state = acc_pkg::ACC_HOLD;
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= acc_pkg::ACC_HOLD;
            cnt <= 12'h000;
            foreground_complete_flag <= 1'b0;
            stopped <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
            foreground_complete_flag <= next_foreground_complete_flag;
            stopped <= next_stopped;
        end
    end

    // Status outputs
    always_comb begin
        case (state)
            acc_pkg::ACC_HOLD: sq.stat = acc_pkg::STAT_HOLD;
            acc_pkg::ACC_FG_LIN, acc_pkg::ACC_FG_OFS: sq.stat = acc_pkg::STAT_FG;
            acc_pkg::ACC_BG_RUN: sq.stat = acc_pkg::STAT_BG;
            acc_pkg::ACC_DONE: sq.stat = acc_pkg::STAT_DONE;
            default: sq.stat = acc_pkg::STAT_RESERVED;
        endcase
    end
    assign sq.foreground_complete_flag = foreground_complete_flag;
    assign sq.stopped = stopped;
    assign sq.div_clear = !sq.run;
endmodule : acc_seq
`default_nettype wire
